// ---- design/bcdma_params.svh ----
/*
 * Register offsets, field positions and reset values for the board
 * control and DMA command register bank.
 * Assumes inclusion by bare name from the package only.
 */
`ifndef BCDMA_PARAMS_SVH
`define BCDMA_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define BCDMA_OFF_FEATURE 8'h00
`define BCDMA_OFF_CMD_A 8'h04
`define BCDMA_OFF_CMD_B 8'h08
`define BCDMA_OFF_RXBASE_A 8'h0C
`define BCDMA_OFF_TXBASE_A 8'h10
`define BCDMA_OFF_RXBASE_B 8'h14
`define BCDMA_OFF_TXBASE_B 8'h18
`define BCDMA_OFF_CURRX_A 8'h20
`define BCDMA_OFF_CURTX_A 8'h24
`define BCDMA_OFF_CURRX_B 8'h28
`define BCDMA_OFF_CURTX_B 8'h2C
`define BCDMA_OFF_STATUS 8'h30

// ----------------------------------------------------------------------
// Feature control fields (port B is port A plus the shift, except async select: bit 25 for B, bit 24 for A)
// ----------------------------------------------------------------------
`define BCDMA_FC_SDATA 0
`define BCDMA_FC_SCLK 1
`define BCDMA_FC_SLATCH 3
`define BCDMA_FC_SYNTH_SHIFT 8
`define BCDMA_FC_ECHO 16
`define BCDMA_FC_TCMD 17
`define BCDMA_FC_TDMD 18
`define BCDMA_FC_LINE_SHIFT 4
`define BCDMA_FC_ASYNC_A 24
`define BCDMA_FC_ASYNC_B 25
`define BCDMA_FC_MASK 32'h0377_0B0B
`define BCDMA_FC_RESET 32'h0000_0000

// ----------------------------------------------------------------------
// Command register fields
// ----------------------------------------------------------------------
`define BCDMA_CMD_GO_R 0
`define BCDMA_CMD_GO_T 1
`define BCDMA_CMD_RST_R 4
`define BCDMA_CMD_RST_T 5
`define BCDMA_CMD_STOP_R 8
`define BCDMA_CMD_STOP_T 9
`define BCDMA_CMD_MRST 16

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define BCDMA_ST_RX_STOPPED_PORT_A 0
`define BCDMA_ST_TX_STOPPED_PORT_A 1
`define BCDMA_ST_RSTOP_B 2
`define BCDMA_ST_TSTOP_B 3
`define BCDMA_ST_MDEAD 4

`define BCDMA_ZERO32 32'h0000_0000

`endif

// ---- design/bcdma_pkg.sv ----
/*
 * Types for the board control and DMA command register bank.
 * Assumes bcdma_params.svh is on the include path.
 */
package bcdma_pkg;
    `include "bcdma_params.svh"

    // AHB-Lite slave inputs grouped together
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
        logic [31:0] hwdata;
    } bcdma_ahb_in_s;

    // Per-port line controls toward the serial front end
    typedef struct packed {
        logic synth_prog_data;
        logic synth_prog_clk;
        logic synth_prog_latch;
        logic rx_enable;
        logic txclk_oe;
        logic txdata_oe;
        logic async_select;
    } bcdma_line_s;

    // One DMA section's control pulses toward the engine
    typedef struct packed {
        logic go;
        logic flush;
        logic stop;
    } bcdma_dma_cmd_s;

    // Per-section activity state
    typedef enum logic [1:0] {
        BCDMA_STOPPED = 2'b01,
        BCDMA_RUNNING = 2'b10
    } bcdma_sect_e;
endpackage

// ---- design/bcdma_regs.sv ----
/*
 * Board control and DMA command register bank, AHB-Lite slave.
 * Assumes one 50 MHz clock, a DMA engine that reports the current
 * descriptor addresses, chain ends and a master fault, and serial
 * cores that report whether each port is transmitting.
 */
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ns
module bcdma_regs (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire bcdma_pkg::bcdma_ahb_in_s ahb_in,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // DMA engine side, index 0 port A, 1 port B
    input wire logic [31:0] cur_rx_desc [2],
    input wire logic [31:0] cur_tx_desc [2],
    input wire logic [1:0] rx_chain_end,
    input wire logic [1:0] tx_chain_end,
    input wire logic master_fault,
    output bcdma_pkg::bcdma_dma_cmd_s rx_cmd [2],
    output bcdma_pkg::bcdma_dma_cmd_s tx_cmd [2],
    output logic master_dma_reset,
    output logic [31:0] rx_desc_base [2],
    output logic [31:0] tx_desc_base [2],
    output logic [1:0] rx_dma_stopped_irq,
    output logic [1:0] tx_dma_stopped_irq,
    // Serial front end
    input wire logic [1:0] port_transmitting,
    output bcdma_pkg::bcdma_line_s line_ctl [2]
);
    import bcdma_pkg::*;

    // ------------------------------------------------------------------
    // Bus address phase capture
    // ------------------------------------------------------------------
    logic wr_pend_r; // Write data phase pending
    logic [7:0] wr_addr_r; // Latched write offset
    logic [31:0] feature_r; // Feature control storage
    logic [31:0] rxbase_r [2]; // Receive descriptor bases
    logic [31:0] txbase_r [2]; // Transmit descriptor bases
    bcdma_sect_e rx_st_r [2]; // Receive section state
    bcdma_sect_e tx_st_r [2]; // Transmit section state
    logic mdead_r; // Master dead flag
    logic [31:0] rd_nxt; // Read mux result
    logic addr_ok; // Valid transfer in address phase
    logic wr_cmd_a; // Command write to port A
    logic wr_cmd_b; // Command write to port B
    logic [31:0] wdata; // Data phase write data

    assign addr_ok = ahb_in.hsel && ahb_in.hready && ahb_in.htrans[1];
    assign wdata = ahb_in.hwdata;
    assign hreadyout = 1'b1; // Zero wait states
    assign hresp = 1'b0; // Always OKAY

    // Capture write address for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else if (ahb_in.hready) begin
            wr_pend_r <= addr_ok && ahb_in.hwrite;
            wr_addr_r <= ahb_in.haddr[7:0];
        end
    end

    // ------------------------------------------------------------------
    // Read data, registered at the address phase
    // ------------------------------------------------------------------
    // Read mux; unmapped offsets read zero
    always_comb begin
        rd_nxt = `BCDMA_ZERO32;
        case (ahb_in.haddr[7:0])
            `BCDMA_OFF_FEATURE: rd_nxt = feature_r;
            `BCDMA_OFF_CMD_A: rd_nxt = `BCDMA_ZERO32;
            `BCDMA_OFF_CMD_B: rd_nxt = `BCDMA_ZERO32;
            `BCDMA_OFF_RXBASE_A: rd_nxt = rxbase_r[0];
            `BCDMA_OFF_TXBASE_A: rd_nxt = txbase_r[0];
            `BCDMA_OFF_RXBASE_B: rd_nxt = rxbase_r[1];
            `BCDMA_OFF_TXBASE_B: rd_nxt = txbase_r[1];
            `BCDMA_OFF_CURRX_A: rd_nxt = cur_rx_desc[0];
            `BCDMA_OFF_CURTX_A: rd_nxt = cur_tx_desc[0];
            `BCDMA_OFF_CURRX_B: rd_nxt = cur_rx_desc[1];
            `BCDMA_OFF_CURTX_B: rd_nxt = cur_tx_desc[1];
            `BCDMA_OFF_STATUS: begin
                rd_nxt[`BCDMA_ST_RX_STOPPED_PORT_A] = rx_st_r[0] == BCDMA_STOPPED;
                rd_nxt[`BCDMA_ST_TX_STOPPED_PORT_A] = tx_st_r[0] == BCDMA_STOPPED;
                rd_nxt[`BCDMA_ST_RSTOP_B] = rx_st_r[1] == BCDMA_STOPPED;
                rd_nxt[`BCDMA_ST_TSTOP_B] = tx_st_r[1] == BCDMA_STOPPED;
                rd_nxt[`BCDMA_ST_MDEAD] = mdead_r;
            end
            default: rd_nxt = `BCDMA_ZERO32;
        endcase
        // Forward a write still in its data phase, so that a read
        // right behind it on a pipelined bus sees the new value
        if (wr_pend_r && wr_addr_r == ahb_in.haddr[7:0]) begin
            case (wr_addr_r)
                `BCDMA_OFF_FEATURE: rd_nxt = wdata & `BCDMA_FC_MASK;
                `BCDMA_OFF_RXBASE_A: rd_nxt = wdata;
                `BCDMA_OFF_TXBASE_A: rd_nxt = wdata;
                `BCDMA_OFF_RXBASE_B: rd_nxt = wdata;
                `BCDMA_OFF_TXBASE_B: rd_nxt = wdata;
                default: ;
            endcase
        end
    end

    // Read data register, loaded on a read address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= `BCDMA_ZERO32;
        end else if (addr_ok && !ahb_in.hwrite) begin
            hrdata <= rd_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Feature control and descriptor bases
    // ------------------------------------------------------------------
    // Feature control; reserved bits held at zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            feature_r <= `BCDMA_FC_RESET;
        end else if (wr_pend_r && wr_addr_r == `BCDMA_OFF_FEATURE) begin
            feature_r <= wdata & `BCDMA_FC_MASK;
        end
    end

    // Descriptor base registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rxbase_r[0] <= `BCDMA_ZERO32;
            rxbase_r[1] <= `BCDMA_ZERO32;
            txbase_r[0] <= `BCDMA_ZERO32;
            txbase_r[1] <= `BCDMA_ZERO32;
        end else if (wr_pend_r) begin
            case (wr_addr_r)
                `BCDMA_OFF_RXBASE_A: rxbase_r[0] <= wdata;
                `BCDMA_OFF_TXBASE_A: txbase_r[0] <= wdata;
                `BCDMA_OFF_RXBASE_B: rxbase_r[1] <= wdata;
                `BCDMA_OFF_TXBASE_B: txbase_r[1] <= wdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Command decode and DMA section state
    // ------------------------------------------------------------------
    assign wr_cmd_a = wr_pend_r && wr_addr_r == `BCDMA_OFF_CMD_A;
    assign wr_cmd_b = wr_pend_r && wr_addr_r == `BCDMA_OFF_CMD_B;

    // One pulse per written one; nothing stored, so reads give zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int p = 0; p < 2; p++) begin
                rx_cmd[p] <= '0;
                tx_cmd[p] <= '0;
            end
            master_dma_reset <= 1'b0;
        end else begin
            // Bits 24 and 25 are not decoded at all
            rx_cmd[0].go <= wr_cmd_a && wdata[`BCDMA_CMD_GO_R];
            tx_cmd[0].go <= wr_cmd_a && wdata[`BCDMA_CMD_GO_T];
            rx_cmd[0].flush <= wr_cmd_a && wdata[`BCDMA_CMD_RST_R];
            tx_cmd[0].flush <= wr_cmd_a && wdata[`BCDMA_CMD_RST_T];
            rx_cmd[0].stop <= wr_cmd_a && wdata[`BCDMA_CMD_STOP_R];
            tx_cmd[0].stop <= wr_cmd_a && wdata[`BCDMA_CMD_STOP_T];
            rx_cmd[1].go <= wr_cmd_b && wdata[`BCDMA_CMD_GO_R];
            tx_cmd[1].go <= wr_cmd_b && wdata[`BCDMA_CMD_GO_T];
            rx_cmd[1].flush <= wr_cmd_b && wdata[`BCDMA_CMD_RST_R];
            tx_cmd[1].flush <= wr_cmd_b && wdata[`BCDMA_CMD_RST_T];
            rx_cmd[1].stop <= wr_cmd_b && wdata[`BCDMA_CMD_STOP_R];
            tx_cmd[1].stop <= wr_cmd_b && wdata[`BCDMA_CMD_STOP_T];
            // Port B bit 16 is ignored
            master_dma_reset <= wr_cmd_a && wdata[`BCDMA_CMD_MRST];
        end
    end

    // Section state per port and direction
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int p = 0; p < 2; p++) begin
                rx_st_r[p] <= BCDMA_STOPPED;
                tx_st_r[p] <= BCDMA_STOPPED;
            end
        end else begin
            for (int p = 0; p < 2; p++) begin
                // Reset, stop or chain end win over go
                if (master_dma_reset || rx_cmd[p].flush ||
                    rx_cmd[p].stop || rx_chain_end[p]) begin
                    rx_st_r[p] <= BCDMA_STOPPED;
                end else if (rx_cmd[p].go) begin
                    rx_st_r[p] <= BCDMA_RUNNING;
                end
                // Same ordering for transmit
                if (master_dma_reset || tx_cmd[p].flush ||
                    tx_cmd[p].stop || tx_chain_end[p]) begin
                    tx_st_r[p] <= BCDMA_STOPPED;
                end else if (tx_cmd[p].go) begin
                    tx_st_r[p] <= BCDMA_RUNNING;
                end
            end
        end
    end

    // Stopped indications, one pulse per stop command, a cycle after it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_dma_stopped_irq <= 2'b00;
            tx_dma_stopped_irq <= 2'b00;
        end else begin
            rx_dma_stopped_irq <= {rx_cmd[1].stop, rx_cmd[0].stop};
            tx_dma_stopped_irq <= {tx_cmd[1].stop, tx_cmd[0].stop};
        end
    end

    // Master dead: fault sets, only master reset clears; set wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mdead_r <= 1'b0;
        end else if (master_fault) begin
            mdead_r <= 1'b1;
        end else if (master_dma_reset) begin
            mdead_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Outputs toward engine and line drivers
    // ------------------------------------------------------------------
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            rx_desc_base[p] = rxbase_r[p];
            tx_desc_base[p] = txbase_r[p];
        end
    end

    // Line controls from flops and transmit activity
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_ctl[0] <= '0;
            line_ctl[1] <= '0;
        end else begin
            for (int p = 0; p < 2; p++) begin
                line_ctl[p].synth_prog_data <=
                    feature_r[`BCDMA_FC_SDATA + p * `BCDMA_FC_SYNTH_SHIFT];
                line_ctl[p].synth_prog_clk <=
                    feature_r[`BCDMA_FC_SCLK + p * `BCDMA_FC_SYNTH_SHIFT];
                line_ctl[p].synth_prog_latch <=
                    feature_r[`BCDMA_FC_SLATCH + p * `BCDMA_FC_SYNTH_SHIFT];
                line_ctl[p].rx_enable <=
                    !(feature_r[`BCDMA_FC_ECHO + p * `BCDMA_FC_LINE_SHIFT]
                      && port_transmitting[p]);
                line_ctl[p].txclk_oe <=
                    !feature_r[`BCDMA_FC_TCMD + p * `BCDMA_FC_LINE_SHIFT]
                    || port_transmitting[p];
                line_ctl[p].txdata_oe <=
                    !feature_r[`BCDMA_FC_TDMD + p * `BCDMA_FC_LINE_SHIFT]
                    || port_transmitting[p];
            end
            line_ctl[0].async_select <= feature_r[`BCDMA_FC_ASYNC_A];
            line_ctl[1].async_select <= feature_r[`BCDMA_FC_ASYNC_B];
        end
    end
endmodule // bcdma_regs

// ---- sim/bcdma_chk.sv ----
/* Checker for the register bank: command pulses and line controls.
   Assumes binding into bcdma_regs; sees only its ports. */
`timescale 1ns/1ns
module bcdma_chk (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus inputs
    input wire bcdma_pkg::bcdma_ahb_in_s ahb_in,
    // Watched outputs
    input wire bcdma_pkg::bcdma_dma_cmd_s rx_cmd [2],
    input wire bcdma_pkg::bcdma_dma_cmd_s tx_cmd [2],
    input wire logic master_dma_reset,
    input wire logic [1:0] rx_dma_stopped_irq,
    input wire logic [1:0] tx_dma_stopped_irq,
    input wire logic [1:0] port_transmitting,
    input wire bcdma_pkg::bcdma_line_s line_ctl [2]
);
    import bcdma_pkg::*;
    // ------------------------------------------
    // Write data phase tracking
    // ------------------------------------------
    logic wr_r; // Write data phase now
    logic [7:0] wa_r; // Its byte address
    // Capture each accepted write address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_r <= 1'b0;
            wa_r <= 8'h00;
        end else if (ahb_in.hready) begin
            wr_r <= ahb_in.hsel & ahb_in.htrans[1] & ahb_in.hwrite;
            wa_r <= ahb_in.haddr[7:0];
        end
    end
    wire w_f = wr_r && wa_r == 8'h00; // Feature write
    wire w_a = wr_r && wa_r == 8'h04; // Port A command
    wire w_b = wr_r && wa_r == 8'h08; // Port B command
    wire mr_a = w_a && ahb_in.hwdata[16]; // Master reset asked
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    rx_go_a: assert property (
        w_a && ahb_in.hwdata[0] |=> rx_cmd[0].go)
        else $error("receive go pulse missing");
    tx_go_a: assert property (
        w_b && ahb_in.hwdata[1] |=> tx_cmd[1].go)
        else $error("transmit go pulse missing");
    go_cause_a: assert property (
        rx_cmd[1].go |-> $past(w_b) && $past(ahb_in.hwdata[0]))
        else $error("receive go without its write");
    tx_flush_a: assert property (
        w_a && ahb_in.hwdata[5] |=> tx_cmd[0].flush ##1 !tx_cmd[0].flush)
        else $error("transmit flush not a single pulse");
    rx_stop_a: assert property (
        w_b && ahb_in.hwdata[8] |=> rx_cmd[1].stop ##1 rx_dma_stopped_irq[1])
        else $error("receive stop or its flag missing");
    tx_stop_a: assert property (
        w_a && ahb_in.hwdata[9] |=> tx_cmd[0].stop ##1 tx_dma_stopped_irq[0])
        else $error("transmit stop or its flag missing");
    mrst_port_a: assert property (
        master_dma_reset |-> $past(mr_a))
        else $error("master reset without port A write");
    en_quiet_a: assert property (
        w_a && (ahb_in.hwdata & 32'h0001_0333) == 32'h0
        |=> rx_cmd[0] == 3'b000 && tx_cmd[0] == 3'b000)
        else $error("command pulse without its bit");
    echo_gate_a: assert property (
        !line_ctl[0].rx_enable && $past(hresetn)
        |-> $past(port_transmitting[0]))
        else $error("receiver off while idle");
    data_oe_a: assert property (
        !line_ctl[1].txdata_oe && $past(hresetn)
        |-> !$past(port_transmitting[1]))
        else $error("data driver off while sending");
    synth_line_a: assert property (
        w_f && ahb_in.hwdata[8] |-> ##[1:2] line_ctl[1].synth_prog_data)
        else $error("synthesiser data line not set");
    async_sel_a: assert property (
        w_f && ahb_in.hwdata[24] |-> ##[1:2] line_ctl[0].async_select)
        else $error("async select not routed");
    cover property (rx_dma_stopped_irq[0]);
    cover property (master_dma_reset);
    cover property (!line_ctl[0].rx_enable);
endmodule // bcdma_chk
bind bcdma_regs bcdma_chk bcdma_chk_inst (.*);

// ---- sim/bcdma_dma_model.sv ----
/* Behavioural DMA engine and serial front end for the bank.
   Assumes the bench asks for chain ends, faults and sending. */
`timescale 1ns/1ns
module bcdma_dma_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // From the register bank
    input wire bcdma_pkg::bcdma_dma_cmd_s rx_cmd [2],
    input wire bcdma_pkg::bcdma_dma_cmd_s tx_cmd [2],
    input wire logic [31:0] rx_desc_base [2],
    input wire logic [31:0] tx_desc_base [2],
    // Bench requests
    input wire logic [3:0] end_rq,
    input wire logic fault_rq,
    input wire logic [1:0] tx_rq,
    // Toward the register bank
    output logic [31:0] cur_rx_desc [2],
    output logic [31:0] cur_tx_desc [2],
    output logic [1:0] rx_chain_end,
    output logic [1:0] tx_chain_end,
    output logic master_fault,
    output logic [1:0] port_transmitting
);
    import bcdma_pkg::*;
    // ------------------------------------------
    // Engine: fetch at base on go, report events
    // ------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_rx_desc <= '{2{32'h0}};
            cur_tx_desc <= '{2{32'h0}};
            rx_chain_end <= 2'h0;
            tx_chain_end <= 2'h0;
            master_fault <= 1'b0;
            port_transmitting <= 2'h0;
        end else begin
            for (int p = 0; p < 2; p++) begin
                // First descriptor is the one at base
                if (rx_cmd[p].go)
                    cur_rx_desc[p] <= rx_desc_base[p];
                if (tx_cmd[p].go)
                    cur_tx_desc[p] <= tx_desc_base[p];
            end
            rx_chain_end <= end_rq[1:0];
            tx_chain_end <= end_rq[3:2];
            master_fault <= fault_rq;
            port_transmitting <= tx_rq;
        end
    end
endmodule // bcdma_dma_model

// ---- sim/tb.sv ----
/* Self-checking bench for bcdma_regs over AHB-Lite with engine model.
   Assumes the design package and its header are compiled first. */
`timescale 1ns/1ns
module tb;
    import bcdma_pkg::*;
    // ------------------------------------------
    // Signals
    // ------------------------------------------
    logic hclk = 1'b0; // 50 MHz clock
    logic hresetn = 1'b0; // Reset, active low
    bcdma_ahb_in_s ab = '0; // Master drive
    bcdma_ahb_in_s ahb_in; // With hready fed back
    logic hreadyout, hresp, master_fault, master_dma_reset;
    logic [31:0] hrdata, cur_rx_desc [2], cur_tx_desc [2];
    logic [31:0] rx_desc_base [2], tx_desc_base [2];
    logic [1:0] rx_chain_end, tx_chain_end, port_transmitting;
    logic [1:0] rx_dma_stopped_irq, tx_dma_stopped_irq;
    bcdma_dma_cmd_s rx_cmd [2], tx_cmd [2];
    bcdma_line_s line_ctl [2];
    logic [3:0] end_rq = 4'h0; // Chain end asks
    logic fault_rq = 1'b0; // Fault ask
    logic [1:0] tx_rq = 2'h0; // Sending asks
    logic [31:0] q, v, fc, bv [4];
    logic [4:0] st = 5'h0F; // Expected status
    logic [7:0] a;
    int n_mismatch = 0, compares = 0, cyc = 0, b;
    always #10 hclk = ~hclk;
    always_comb begin
        ahb_in = ab;
        ahb_in.hready = hreadyout;
    end
    bcdma_regs bcdma_regs_inst (.*);
    bcdma_dma_model bcdma_dma_model_inst (.*);
    // ------------------------------------------
    // Tasks and expectations
    // ------------------------------------------
    task automatic close_out();
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // One word transfer, waits for hready at each phase
    task automatic bus(input logic w, input logic [7:0] ad,
                       input logic [31:0] d);
        ab.hsel <= 1'b1;
        ab.htrans <= 2'b10;
        ab.haddr <= {24'h0, ad};
        ab.hwrite <= w;
        ab.hsize <= 3'b010;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        ab.htrans <= 2'b00;
        ab.hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] e);
        bus(1'b0, ad, 32'h0);
        chk(q, e);
    endtask
    // Write, then let pulses and status settle
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        bus(1'b1, ad, d);
        repeat (3) @(posedge hclk);
    endtask
    function automatic bcdma_line_s xl(input logic [31:0] f,
                                       input int p, input logic t);
        return {f[8*p], f[8*p+1], f[8*p+3], !(f[16+4*p] && t),
                !f[17+4*p] || t, !f[18+4*p] || t, f[24+p]};
    endfunction
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            close_out();
        end
    end
    // ------------------------------------------
    // Main sequence
    // ------------------------------------------
    initial begin
        q = $urandom(41427);
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(8'h00, 32'h0);
        rd(8'h30, 32'h0F);
        for (int i = 0; i < 4; i++) begin
            a = 8'h0C + 8'(4 * i);
            bv[i] = $urandom();
            wr(a, bv[i]);
            rd(a, bv[i]);
            chk(i[0] ? tx_desc_base[i/2] : rx_desc_base[i/2], bv[i]);
        end
        wr(8'h1C, 32'hFFFF_FFFF);
        rd(8'h1C, 32'h0);
        for (int c = 0; c < 8; c++) begin
            a = c[2] ? 8'h08 : 8'h04;
            b = 2 * c[2] + c[0];
            wr(a, 32'h1 << c[0]);
            st[b] = 1'b0;
            rd(8'h30, {27'h0, st});
            rd(a, 32'h0);
            wr(8'h20 + 8'(4 * b), ~bv[b]);
            rd(8'h20 + 8'(4 * b), bv[b]);
            wr(a, 32'h0300_0000);
            rd(8'h30, {27'h0, st});
            wr(a, (c[1] ? 32'h100 : 32'h10) << c[0]);
            st[b] = 1'b1;
            rd(8'h30, {27'h0, st});
        end
        wr(8'h08, 32'h3);
        rd(8'h30, 32'h03);
        end_rq <= 4'b1010;
        @(posedge hclk);
        end_rq <= 4'h0;
        repeat (3) @(posedge hclk);
        wr(8'h30, 32'hFFFF_FFFF);
        rd(8'h30, {27'h0, st});
        fault_rq <= 1'b1;
        @(posedge hclk);
        fault_rq <= 1'b0;
        repeat (3) @(posedge hclk);
        st[4] = 1'b1;
        rd(8'h30, {27'h0, st});
        wr(8'h08, 32'h0001_0000);
        rd(8'h30, {27'h0, st});
        wr(8'h04, 32'h0001_0000);
        st[4] = 1'b0;
        rd(8'h30, {27'h0, st});
        for (int i = 0; i < 12; i++) begin
            v = (i < 2) ? 32'hFFFF_FFFF : $urandom();
            fc = v & 32'h0377_0B0B;
            tx_rq <= (i < 2) ? 2'(3 * i) : 2'($urandom());
            wr(8'h00, v);
            rd(8'h00, fc);
            chk({line_ctl[1], line_ctl[0]}, {xl(fc, 1, tx_rq[1]), xl(fc, 0, tx_rq[0])});
        end
        // Mid-run reset with sections running and features set
        wr(8'h04, 32'h3);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(8'h00, 32'h0);
        rd(8'h30, 32'h0F);
        close_out();
    end
endmodule // tb
